// *** core/cdac_cfg.svh ***
// Offsets, field positions, reset values and masks for the current DAC control
// Assumes inclusion by bare name from the design files of this block
`ifndef CDAC_CFG_SVH
`define CDAC_CFG_SVH
`define CDAC_ADDR_W       8
`define CDAC_OFS_CTRL     8'hb9
`define CDAC_OFS_DATA_HI  8'h97
`define CDAC_OFS_DATA_LO  8'h96
`define CDAC_CTRL_EN_BIT  7
`define CDAC_CTRL_SRC_HI  6
`define CDAC_CTRL_SRC_LO  4
`define CDAC_CTRL_FS_HI   1
`define CDAC_CTRL_FS_LO   0
`define CDAC_CTRL_RST     8'h72
`define CDAC_DATA_HI_RST  8'h00
`define CDAC_DATA_LO_RST  8'h00
`define CDAC_LO_MASK      8'hc0
`define CDAC_CTRL_MASK    8'hf3
`endif

// *** core/cdac_ctrl.sv ***
// Digital control of a 10-bit current-output converter: registers, update
// scheduling, pin ownership, bias enable and full-scale selection.
// Assumes a single-cycle register port and timer overflow pulses on ref_clk_i.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cdac_cfg.svh"
module cdac_ctrl #(
  parameter int CODE_W = 10
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [`CDAC_ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]              reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [7:0]              reg_rdata_o,
  input  wire logic [3:0]              timer_ovf_i,
  input  wire logic                    external_convert_strobe_i,
  output logic      [CODE_W-1:0]       dac_code_o,
  output logic      [1:0]              fullscale_select_field_o,
  output logic                         converter_enable_bit_o,
  output logic                         bias_enable_o,
  output logic                         pin_analog_connect_o,
  output logic                         pin_digital_off_o,
  output logic                         pin_pullup_off_o
);
  // Elaboration check: the byte mapping serves a 10-bit code only
  if (CODE_W != 10) begin : gen_bad_code_w
    $error("cdac_ctrl supports a 10-bit code only");
  end

  // Control and data registers
  logic [7:0]        ctrl_r, ctrl_nxt;
  logic [7:0]        data_hi_r, data_hi_nxt;
  logic [7:0]        data_lo_r, data_lo_nxt;
  logic [CODE_W-1:0] code_r, code_nxt;
  logic [7:0]        rdata_r, rdata_nxt;
  // Strobe synchroniser and edge history
  logic              strb_s1_r, strb_s2_r, strb_s3_r;
  logic              rise_w, fall_w, update_w;
  cdac_pkg::cdac_src_t src_w;

  // High data byte write, shared by update logic and its check
  function automatic logic hi_wr_hit(
    input logic                    wr,
    input logic [`CDAC_ADDR_W-1:0] addr
  );
    return wr && (addr == `CDAC_OFS_DATA_HI);
  endfunction

  // Edges come from the second and third flops, so the pin is never
  // read before it has passed two flip-flops
  assign src_w = cdac_pkg::cdac_src_t'(
    ctrl_r[`CDAC_CTRL_SRC_HI:`CDAC_CTRL_SRC_LO]);
  assign rise_w = strb_s2_r & ~strb_s3_r;
  assign fall_w = ~strb_s2_r & strb_s3_r;

  // Update event selection
  always_comb begin
    update_w = 1'b0;
    unique case (src_w)
      cdac_pkg::CDAC_SRC_T0:    update_w = timer_ovf_i[0];
      cdac_pkg::CDAC_SRC_T1:    update_w = timer_ovf_i[1];
      cdac_pkg::CDAC_SRC_T2:    update_w = timer_ovf_i[2];
      cdac_pkg::CDAC_SRC_T3:    update_w = timer_ovf_i[3];
      cdac_pkg::CDAC_SRC_RISE:  update_w = rise_w;
      cdac_pkg::CDAC_SRC_FALL:  update_w = fall_w;
      cdac_pkg::CDAC_SRC_ANY:   update_w = rise_w | fall_w;
      cdac_pkg::CDAC_SRC_WRITE: begin
        update_w = hi_wr_hit(reg_wr_i, reg_addr_i);
      end
    endcase
  end

  // Register writes, code latch and read mux
  always_comb begin
    ctrl_nxt    = ctrl_r;
    data_hi_nxt = data_hi_r;
    data_lo_nxt = data_lo_r;
    code_nxt    = code_r;
    rdata_nxt   = 8'h00;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `CDAC_OFS_CTRL:    ctrl_nxt    = reg_wdata_i & `CDAC_CTRL_MASK;
        `CDAC_OFS_DATA_HI: data_hi_nxt = reg_wdata_i;
        `CDAC_OFS_DATA_LO: data_lo_nxt = reg_wdata_i & `CDAC_LO_MASK;
        default:           ctrl_nxt    = ctrl_r;
      endcase
    end
    if (update_w) begin
      code_nxt = {data_hi_nxt, data_lo_nxt[7:6]};
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `CDAC_OFS_CTRL:    rdata_nxt = ctrl_r;
        `CDAC_OFS_DATA_HI: rdata_nxt = data_hi_r;
        `CDAC_OFS_DATA_LO: rdata_nxt = data_lo_r;
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r    <= `CDAC_CTRL_RST;
      data_hi_r <= `CDAC_DATA_HI_RST;
      data_lo_r <= `CDAC_DATA_LO_RST;
      code_r    <= '0;
      rdata_r   <= 8'h00;
      strb_s1_r <= 1'b0;
      strb_s2_r <= 1'b0;
      strb_s3_r <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      data_hi_r <= data_hi_nxt;
      data_lo_r <= data_lo_nxt;
      code_r    <= code_nxt;
      rdata_r   <= rdata_nxt;
      strb_s1_r <= external_convert_strobe_i;
      strb_s2_r <= strb_s1_r;
      strb_s3_r <= strb_s2_r;
    end
  end

  // Converter outputs and pin ownership
  assign reg_rdata_o   = rdata_r;
  assign dac_code_o    = code_r;
  assign converter_enable_bit_o = ctrl_r[`CDAC_CTRL_EN_BIT];
  assign fullscale_select_field_o = ctrl_r[`CDAC_CTRL_FS_HI] ?
    cdac_pkg::CDAC_FS_2MA : ctrl_r[`CDAC_CTRL_FS_HI:`CDAC_CTRL_FS_LO];
  assign bias_enable_o        = ctrl_r[`CDAC_CTRL_EN_BIT];
  assign pin_analog_connect_o = ctrl_r[`CDAC_CTRL_EN_BIT];
  assign pin_digital_off_o    = ctrl_r[`CDAC_CTRL_EN_BIT];
  assign pin_pullup_off_o     = ctrl_r[`CDAC_CTRL_EN_BIT];

  // Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Update scheduling checks
  hi_write_latch_a: assert property (
    (src_w == cdac_pkg::CDAC_SRC_WRITE && hi_wr_hit(reg_wr_i, reg_addr_i))
    |=> dac_code_o == {$past(reg_wdata_i), data_lo_r[7:6]})
    else $error("high byte write did not latch code");
  lo_write_hold_a: assert property (
    (src_w == cdac_pkg::CDAC_SRC_WRITE && reg_wr_i &&
     reg_addr_i == `CDAC_OFS_DATA_LO) |=> $stable(dac_code_o))
    else $error("low byte write changed output");
  timer_update_a: assert property (
    (src_w == cdac_pkg::CDAC_SRC_T2 && timer_ovf_i[2] && !reg_wr_i)
    |=> dac_code_o == {data_hi_r, data_lo_r[7:6]})
    else $error("timer overflow did not update code");
  no_event_hold_a: assert property (
    !update_w |=> $stable(dac_code_o))
    else $error("code changed without update event");
  rise_edge_a: assert property (
    (src_w == cdac_pkg::CDAC_SRC_RISE && !reg_wr_i &&
     !strb_s3_r && strb_s2_r) |-> update_w)
    else $error("rising strobe edge missed");
  fall_edge_a: assert property (
    (src_w == cdac_pkg::CDAC_SRC_FALL && fall_w) |-> update_w)
    else $error("falling strobe edge missed");
  any_edge_a: assert property (
    (src_w == cdac_pkg::CDAC_SRC_ANY && (rise_w || fall_w)) |-> update_w)
    else $error("strobe edge missed in any-edge mode");
  timer_hold_a: assert property (
    (src_w == cdac_pkg::CDAC_SRC_T0 && !timer_ovf_i[0])
    |=> $stable(dac_code_o))
    else $error("code changed without timer 0 overflow");

  // Register format and read idle checks
  fs_decode_a: assert property (
    ctrl_r[`CDAC_CTRL_FS_HI] |-> fullscale_select_field_o == 2'b10)
    else $error("1x code not mapped to 2 mA");
  fs_pass_a: assert property (
    !ctrl_r[`CDAC_CTRL_FS_HI] |-> fullscale_select_field_o == ctrl_r[1:0])
    else $error("0x full-scale code not passed through");
  ctrl_unused_a: assert property (
    ctrl_r[3:2] == 2'b00)
    else $error("unused control bits not zero");
  lo_unused_a: assert property (
    data_lo_r[5:0] == 6'h00)
    else $error("unused low data bits not zero");
  read_idle_a: assert property (
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not cleared after read");

  // Pin ownership and control readback checks
  bias_follow_a: assert property (
    bias_enable_o == converter_enable_bit_o)
    else $error("bias enable differs from enable bit");
  enable_pins_a: assert property (
    converter_enable_bit_o |-> pin_digital_off_o && pin_pullup_off_o &&
    pin_analog_connect_o && bias_enable_o)
    else $error("enable did not take the pin");
  disable_gpio_a: assert property (
    !converter_enable_bit_o |-> !pin_digital_off_o && !pin_analog_connect_o &&
    !pin_pullup_off_o && !bias_enable_o)
    else $error("disabled converter still holds pin");
  read_ctrl_a: assert property (
    (reg_rd_i && reg_addr_i == `CDAC_OFS_CTRL)
    |=> reg_rdata_o == $past(ctrl_r))
    else $error("control readback wrong");

  write_mode_c: cover property (src_w == cdac_pkg::CDAC_SRC_WRITE && update_w);
  timer_mode_c: cover property (src_w == cdac_pkg::CDAC_SRC_T0 && update_w);
  any_edge_c:   cover property (src_w == cdac_pkg::CDAC_SRC_ANY && fall_w);
  fall_mode_c:  cover property (src_w == cdac_pkg::CDAC_SRC_FALL && update_w);
  enabled_c:    cover property (converter_enable_bit_o);
endmodule
`default_nettype wire

// *** core/cdac_pkg.sv ***
// Types shared by the current DAC control block
// Assumes the _cfg header supplies all numeric constants
package cdac_pkg;
  typedef enum logic [2:0] {
    CDAC_SRC_T0    = 3'b000,
    CDAC_SRC_T1    = 3'b001,
    CDAC_SRC_T2    = 3'b010,
    CDAC_SRC_T3    = 3'b011,
    CDAC_SRC_RISE  = 3'b100,
    CDAC_SRC_FALL  = 3'b101,
    CDAC_SRC_ANY   = 3'b110,
    CDAC_SRC_WRITE = 3'b111
  } cdac_src_t;
  typedef enum logic [1:0] {
    CDAC_FS_0P5MA = 2'b00,
    CDAC_FS_1MA   = 2'b01,
    CDAC_FS_2MA   = 2'b10
  } cdac_fs_t;
endpackage

// *** sim/cdac_ctrl_tb_top.sv ***
// Bench for the current DAC control: register tasks and checked sequences
// Assumes the single-cycle register port and 40 MHz clock of the design
`timescale 1ns/1ps
`default_nettype none
`include "cdac_cfg.svh"
module cdac_ctrl_tb_top;
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic       wr        = 1'b0;
  logic       rd        = 1'b0;
  logic       strb      = 1'b0;
  logic [3:0] tmr       = 4'h0;
  logic [7:0] rdata;
  logic [9:0] code;
  logic [9:0] exp;
  logic [1:0] fs;
  logic       en, bias, ana, doff, puoff;
  int         err_total   = 0;
  int         comparisons = 0;

  cdac_ctrl cdac_ctrl_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .timer_ovf_i(tmr), .external_convert_strobe_i(strb),
    .dac_code_o(code), .fullscale_select_field_o(fs),
    .converter_enable_bit_o(en), .bias_enable_o(bias),
    .pin_analog_connect_o(ana), .pin_digital_off_o(doff),
    .pin_pullup_off_o(puoff));

  // Free-running 25 ns clock
  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // Compare one result and count it
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // Compare one read data byte and count it
  task automatic chk_rd(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // One-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask

  // Read strobe, then check data in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    chk_rd("read data", e, rdata);
    @(posedge ref_clk_i);
    #1;
    chk_rd("read idle", 8'h00, rdata);
  endtask

  // One-cycle overflow pulse of timer n
  task automatic tick(input int n);
    @(posedge ref_clk_i);
    tmr <= 4'h1 << n;
    @(posedge ref_clk_i);
    tmr <= 4'h0;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask

  // Strobe pin edge, then check the code after the synchroniser
  task automatic edge_chk(input logic lvl, input logic [9:0] e);
    @(posedge ref_clk_i);
    strb <= lvl;
    repeat (6) @(posedge ref_clk_i);
    #1;
    chk("strobe code", e, code);
  endtask

  // Closing report
  task automatic give_verdict;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    err_total++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("pins", 10'h000, {5'h00, en, bias, ana, doff, puoff});
    chk("fullscale", 10'h002, {8'h00, fs});
    rd_chk(`CDAC_OFS_CTRL, `CDAC_CTRL_RST);
    rd_chk(8'h55, 8'h00);
    wr_reg(`CDAC_OFS_DATA_LO, 8'hff);
    chk("held code", 10'h000, code);
    rd_chk(`CDAC_OFS_DATA_LO, 8'hc0);
    wr_reg(`CDAC_OFS_DATA_HI, 8'h81);
    chk("write code", 10'h207, code);
    exp = 10'h207;
    for (int f = 0; f < 4; f++) begin
      wr_reg(`CDAC_OFS_CTRL, 8'hfc | 8'(f));
      chk("pins", 10'h01f, {5'h00, en, bias, ana, doff, puoff});
      chk("fullscale", (f > 1) ? 10'h002 : 10'(f), {8'h00, fs});
      rd_chk(`CDAC_OFS_CTRL, 8'hf0 | 8'(f));
    end
    wr_reg(`CDAC_OFS_DATA_LO, 8'h40);
    for (int n = 0; n < 4; n++) begin
      wr_reg(`CDAC_OFS_CTRL, 8'h82 | 8'(n << 4));
      wr_reg(`CDAC_OFS_DATA_HI, 8'(n));
      tick((n + 1) % 4);
      chk("timer held", exp, code);
      tick(n);
      exp = {8'(n), 2'b01};
      chk("timer code", exp, code);
    end
    for (int m = 0; m < 3; m++) begin
      wr_reg(`CDAC_OFS_CTRL, 8'hc2 | 8'(m << 4));
      wr_reg(`CDAC_OFS_DATA_HI, 8'(2 * m + 16));
      if (m != 1) exp = {8'(2 * m + 16), 2'b01};
      edge_chk(1'b1, exp);
      wr_reg(`CDAC_OFS_DATA_HI, 8'(2 * m + 17));
      if (m != 0) exp = {8'(2 * m + 17), 2'b01};
      edge_chk(1'b0, exp);
    end
    // Mid-run reset returns every register to its reset value
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("reset code", 10'h000, code);
    chk("pins", 10'h000, {5'h00, en, bias, ana, doff, puoff});
    rd_chk(`CDAC_OFS_DATA_HI, 8'h00);
    rd_chk(`CDAC_OFS_CTRL, `CDAC_CTRL_RST);
    wr_reg(`CDAC_OFS_CTRL, 8'hf2);
    chk("pins", 10'h01f, {5'h00, en, bias, ana, doff, puoff});
    wr_reg(`CDAC_OFS_CTRL, `CDAC_CTRL_RST);
    chk("pins", 10'h000, {5'h00, en, bias, ana, doff, puoff});
    give_verdict();
  end
endmodule
`default_nettype wire
